//--- rtl/clock_config_pkg.sv
/*
 Constants, types and decode functions for the clock configuration block.
 Assumes one 25 MHz clock and a synchronous active-high reset.
*/
// Functional notes
// [R01] config word resets zero; software writes only
// [R02] zero waits; one or two during switch
// [R03] select: rc, external, multiplied, reserved
// [R04] force rc on wake or external failure; code forces on failure only with security_en_i set and external in use
// [R05] status field reports actual root source
// [R06] core divider: 1,2,4,8,16,64,128,256,512
// [R07] software enables prefetch when core divides
// [R08] low-speed divider: 1,2,4,8,16 of core
// [R09] software keeps low-speed clock under 48MHz
// [R10] high-speed divider, same encoding as low
// [R11] converter divider: 2,4,6,8 of high-speed
// [R12] multiplier reference: rc halved or external
// [R13] external predivider: pass or halve
// [R14] multiplier fields locked while multiplier enabled
// [R15] factor field sets ratio two to sixteen
// [R16] software keeps multiplied clock under 96MHz
// [R17] usb divider: 1.5, 1, 2, reserved
// [R18] software sets usb divider before enabling
// [R19] usb divider locked while usb clock on
// [R20] clock output pin source select
// [R21] factor is code plus two, saturating
// [R22] glitch-free switch, status after completion
package clock_config_pkg;

    localparam logic [7:0]  CFG_OFFSET         = 8'h04;
    localparam logic [31:0] CFG_RESET          = 32'h0000_0000;
    localparam logic [31:0] STATUS_MASK        = 32'h0000_000C;
    localparam logic [31:0] MULT_FIELDS_MASK   = 32'h003F_0000;
    localparam logic [31:0] USB_FIELD_MASK     = 32'h00C0_0000;
    localparam logic [31:0] RESERVED_MASK      = 32'hF800_0000;
    localparam logic [1:0]  SWITCH_GAP_CYCLES  = 2'h2;
    localparam logic [1:0]  ACCESS_WAIT_CYCLES = 2'h2;

    typedef enum logic [1:0] {SRC_RC, SRC_EXT, SRC_MULT, SRC_RSVD} source_e;
    typedef enum logic [1:0] {SW_IDLE, SW_WAIT_READY, SW_GAP} switch_e;

    typedef struct packed {
        logic [4:0] reserved;
        logic [2:0] clock_output_select;
        logic [1:0] usb_clock_divider;
        logic [3:0] multiplication_factor;
        logic       external_predivider;
        logic       multiplier_source_select;
        logic [1:0] converter_clock_divider;
        logic [2:0] high_speed_bus_divider;
        logic [2:0] low_speed_bus_divider;
        logic [3:0] core_bus_divider;
        source_e    root_source_status;
        source_e    root_source_select;
    } cfg_s;

    typedef struct packed {
        cfg_s       cfg;
        switch_e    sw;
        source_e    target;
        logic [1:0] gap;
        logic [1:0] wt;
        logic       waiting;
        logic       ack;
        logic [31:0] rdata;
        logic [8:0] core_cnt;
        logic [3:0] low_cnt;
        logic [3:0] high_cnt;
        logic [2:0] conv_cnt;
        logic       core_tick;
        logic       low_tick;
        logic       high_tick;
        logic       conv_tick;
        logic [4:0] factor;
        logic       switching;
    } state_s;

    function automatic logic [9:0] core_ratio(input logic [3:0] code);
        if (!code[3]) begin
            return 10'h001;
        end
        if (code[2]) begin
            return 10'h040 << code[1:0];
        end
        return 10'h002 << code[1:0];
    endfunction

    function automatic logic [4:0] bus_ratio(input logic [2:0] code);
        if (!code[2]) begin
            return 5'h01;
        end
        return 5'h02 << code[1:0];
    endfunction

    function automatic logic [3:0] conv_ratio(input logic [1:0] code);
        return {1'b0, code, 1'b0} + 4'h2;
    endfunction

    function automatic logic [4:0] mult_ratio(input logic [3:0] code);
        if (code == 4'hF) begin
            return 5'h10;
        end
        return {1'b0, code} + 5'h02;
    endfunction

endpackage

//--- rtl/system_clock_config.sv
/*
 Clock configuration register with root source switch control, divider
 tick generation and clock output selection, reached over classic Wishbone.
 Assumes ready and failure inputs are synchronous to clk_i.
*/
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module system_clock_config
    import clock_config_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // oscillator and power state
    input  wire logic        rc_ready_i,
    input  wire logic        ext_ready_i,
    input  wire logic        mult_ready_i,
    input  wire logic        wake_i,
    input  wire logic        security_en_i,
    input  wire logic        ext_fail_i,
    input  wire logic        mult_enabled_i,
    input  wire logic        usb_clk_enabled_i,
    // root source control
    output logic      [1:0]  root_source_o,
    output logic             switching_o,
    // divided rate enables
    output logic             core_tick_o,
    output logic             low_speed_tick_o,
    output logic             high_speed_tick_o,
    output logic             converter_tick_o,
    // multiplier and usb setup
    output logic             mult_ref_ext_o,
    output logic             ext_predivide_o,
    output logic      [4:0]  mult_factor_o,
    output logic      [1:0]  usb_div_o,
    // clock output pin
    output logic      [2:0]  clock_output_sel_o
);

    state_s      s_r;
    state_s      s_nxt;
    logic        access;
    logic        busy;
    logic        hit;
    logic        ext_in_use;
    logic        src_ready;
    logic [31:0] lane_mask;
    logic [31:0] keep_mask;
    logic [31:0] merged;
    logic [9:0]  cr;
    logic [4:0]  lr;
    logic [4:0]  hr;
    logic [3:0]  vr;

    always_comb begin
        s_nxt      = s_r;
        access     = cyc_i && stb_i && !s_r.ack;
        busy       = (s_r.sw != SW_IDLE);
        hit        = (adr_i[7:2] == CFG_OFFSET[7:2]);
        ext_in_use = (s_r.cfg.root_source_status == SRC_EXT)
                     || (s_r.cfg.root_source_status == SRC_MULT && s_r.cfg.multiplier_source_select);
        lane_mask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        // [R14] [R19] locked field groups
        keep_mask  = STATUS_MASK | RESERVED_MASK
                     | (mult_enabled_i ? MULT_FIELDS_MASK : 32'h0000_0000)
                     | (usb_clk_enabled_i ? USB_FIELD_MASK : 32'h0000_0000);
        merged     = (s_r.cfg & ~lane_mask) | (dat_i & lane_mask);
        merged     = (merged & ~keep_mask) | (s_r.cfg & keep_mask);
        src_ready  = 1'b0;
        // [R03] select code to source
        unique case (s_r.target)
            SRC_RC:   src_ready = rc_ready_i;
            SRC_EXT:  src_ready = ext_ready_i;
            SRC_MULT: src_ready = mult_ready_i;
            default:  src_ready = 1'b0;
        endcase

        // bus handshake
        s_nxt.ack = 1'b0;
        // [R02] waits only while switching
        if (access && !s_r.waiting) begin
            if (busy) begin
                s_nxt.waiting = 1'b1;
                s_nxt.wt      = ACCESS_WAIT_CYCLES;
            end else begin
                s_nxt.ack   = 1'b1;
                s_nxt.rdata = hit ? s_r.cfg : 32'h0000_0000;
            end
        end else if (access) begin
            s_nxt.wt = s_r.wt - 2'h1;
            if (s_r.wt == 2'h1 || !busy) begin
                s_nxt.waiting = 1'b0;
                s_nxt.ack     = 1'b1;
                s_nxt.rdata   = hit ? s_r.cfg : 32'h0000_0000;
            end
        end else begin
            s_nxt.waiting = 1'b0;
        end
        // [R01] software write at acknowledge
        if (s_r.ack && cyc_i && stb_i && we_i && hit) begin
            s_nxt.cfg = merged;
        end

        // [R22] source switch sequence
        unique case (s_r.sw)
            SW_IDLE: begin
                if (s_nxt.cfg.root_source_select != SRC_RSVD
                        && s_nxt.cfg.root_source_select != s_r.cfg.root_source_status) begin
                    s_nxt.sw     = SW_WAIT_READY;
                    s_nxt.target = s_nxt.cfg.root_source_select;
                end
            end
            SW_WAIT_READY: begin
                if (s_nxt.cfg.root_source_select != s_r.target) begin
                    s_nxt.sw = SW_IDLE;
                end else if (src_ready) begin
                    s_nxt.sw  = SW_GAP;
                    s_nxt.gap = SWITCH_GAP_CYCLES;
                end
            end
            SW_GAP: begin
                s_nxt.gap = s_r.gap - 2'h1;
                if (s_r.gap == 2'h1) begin
                    s_nxt.sw = SW_IDLE;
                    // [R05] status follows completed switch
                    s_nxt.cfg.root_source_status = s_r.target;
                end
            end
        endcase
        // [R04] forced fallback to rc
        if (wake_i || (security_en_i && ext_fail_i && ext_in_use)) begin
            s_nxt.cfg.root_source_select = SRC_RC;
            s_nxt.cfg.root_source_status = SRC_RC;
            s_nxt.sw                     = SW_IDLE;
        end
        // [R22] registered gap flag
        s_nxt.switching = (s_nxt.sw == SW_GAP);

        // [R06] core rate
        cr = core_ratio(s_r.cfg.core_bus_divider);
        // [R08] low-speed rate
        lr = bus_ratio(s_r.cfg.low_speed_bus_divider);
        // [R10] high-speed rate
        hr = bus_ratio(s_r.cfg.high_speed_bus_divider);
        // [R11] converter rate
        vr = conv_ratio(s_r.cfg.converter_clock_divider);
        s_nxt.core_tick = ({1'b0, s_r.core_cnt} >= cr - 10'h001);
        s_nxt.core_cnt  = s_nxt.core_tick ? 9'h000 : s_r.core_cnt + 9'h001;
        s_nxt.low_tick  = 1'b0;
        s_nxt.high_tick = 1'b0;
        if (s_nxt.core_tick) begin
            s_nxt.low_tick  = ({1'b0, s_r.low_cnt} >= lr - 5'h01);
            s_nxt.low_cnt   = s_nxt.low_tick ? 4'h0 : s_r.low_cnt + 4'h1;
            s_nxt.high_tick = ({1'b0, s_r.high_cnt} >= hr - 5'h01);
            s_nxt.high_cnt  = s_nxt.high_tick ? 4'h0 : s_r.high_cnt + 4'h1;
        end
        s_nxt.conv_tick = 1'b0;
        if (s_nxt.high_tick) begin
            s_nxt.conv_tick = ({1'b0, s_r.conv_cnt} >= vr - 4'h1);
            s_nxt.conv_cnt  = s_nxt.conv_tick ? 3'h0 : s_r.conv_cnt + 3'h1;
        end
        // [R15] [R21] decoded factor
        s_nxt.factor = mult_ratio(s_nxt.cfg.multiplication_factor);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r        <= '0;
            s_r.cfg    <= CFG_RESET;
            s_r.factor <= mult_ratio(CFG_RESET[21:18]);
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dat_o              = s_r.rdata;
    assign ack_o              = s_r.ack;
    assign root_source_o      = s_r.cfg.root_source_status;
    // [R22] root clock gated during switch
    assign switching_o        = s_r.switching;
    assign core_tick_o        = s_r.core_tick;
    assign low_speed_tick_o   = s_r.low_tick;
    assign high_speed_tick_o  = s_r.high_tick;
    assign converter_tick_o   = s_r.conv_tick;
    // [R12] multiplier reference
    assign mult_ref_ext_o     = s_r.cfg.multiplier_source_select;
    // [R13] external predivider
    assign ext_predivide_o    = s_r.cfg.external_predivider;
    assign mult_factor_o      = s_r.factor;
    // [R17] usb divider code
    assign usb_div_o          = s_r.cfg.usb_clock_divider;
    // [R20] clock output select
    assign clock_output_sel_o = s_r.cfg.clock_output_select;

endmodule
`default_nettype wire

//--- dv/system_clock_config_assertions.sv
/*
 Concurrent checks on the clock configuration block ports.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module system_clock_config_assertions (
    // watched ports
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic       wake_i,
    input wire logic       security_en_i,
    input wire logic       ext_fail_i,
    input wire logic       mult_enabled_i,
    input wire logic       usb_clk_enabled_i,
    input wire logic [1:0] root_source_o,
    input wire logic       switching_o,
    input wire logic       core_tick_o,
    input wire logic       low_speed_tick_o,
    input wire logic [4:0] mult_factor_o,
    input wire logic [1:0] usb_div_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    ack_bound_a: assert property (cyc_i && stb_i && !ack_o |-> ##[1:3] ack_o) else $error("ack late");
    gap_length_a: assert property ($rose(switching_o) |=> switching_o ##1 !switching_o)
        else $error("switch gap not two cycles");
    status_cause_a: assert property ($changed(root_source_o) |-> $past(switching_o) || $past(switching_o, 2)
        || $past(wake_i) || $past(ext_fail_i)) else $error("status changed without cause");
    wake_force_a: assert property (wake_i |=> root_source_o == 2'h0) else $error("wake did not force rc");
    fail_force_a: assert property (security_en_i && ext_fail_i && root_source_o == 2'h1 |=>
        root_source_o == 2'h0) else $error("failure did not force rc");
    factor_range_a: assert property (mult_factor_o >= 5'h02 && mult_factor_o <= 5'h10)
        else $error("factor out of range");
    mult_lock_a: assert property (mult_enabled_i && $past(mult_enabled_i) && $past(mult_enabled_i, 2) |->
        $stable(mult_factor_o)) else $error("factor changed while locked");
    usb_lock_a: assert property (usb_clk_enabled_i && $past(usb_clk_enabled_i) && $past(usb_clk_enabled_i, 2)
        |-> $stable(usb_div_o)) else $error("usb divider changed while locked");
    tick_align_a: assert property (low_speed_tick_o |-> core_tick_o) else $error("low tick off core tick");
endmodule
bind system_clock_config system_clock_config_assertions system_clock_config_assertions_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .wake_i(wake_i),
    .security_en_i(security_en_i), .ext_fail_i(ext_fail_i), .mult_enabled_i(mult_enabled_i),
    .usb_clk_enabled_i(usb_clk_enabled_i), .root_source_o(root_source_o), .switching_o(switching_o),
    .core_tick_o(core_tick_o), .low_speed_tick_o(low_speed_tick_o), .mult_factor_o(mult_factor_o),
    .usb_div_o(usb_div_o));
`default_nettype wire

//--- dv/system_clock_config_test.sv
/*
 Self-checking bench for the clock configuration block.
 Assumes the block answers on classic Wishbone at offset 0x04.
*/
`timescale 1ns/10ps
`default_nettype none
module system_clock_config_test;
    import clock_config_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, switching_o;
    logic rc_ready_i, ext_ready_i, mult_ready_i, wake_i, security_en_i, ext_fail_i;
    logic mult_enabled_i, usb_clk_enabled_i, mult_ref_ext_o, ext_predivide_o;
    logic core_tick_o, low_speed_tick_o, high_speed_tick_o, converter_tick_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, w, e, q;
    logic [1:0]  root_source_o, usb_div_o;
    logic [4:0]  mult_factor_o;
    logic [2:0]  clock_output_sel_o;
    int          n_errors, checked, i;
    logic [31:0] t [4];
    system_clock_config system_clock_config_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rc_ready_i(rc_ready_i),
        .ext_ready_i(ext_ready_i), .mult_ready_i(mult_ready_i), .wake_i(wake_i), .security_en_i(security_en_i),
        .ext_fail_i(ext_fail_i), .mult_enabled_i(mult_enabled_i), .usb_clk_enabled_i(usb_clk_enabled_i),
        .root_source_o(root_source_o), .switching_o(switching_o), .core_tick_o(core_tick_o),
        .low_speed_tick_o(low_speed_tick_o), .high_speed_tick_o(high_speed_tick_o),
        .converter_tick_o(converter_tick_o), .mult_ref_ext_o(mult_ref_ext_o),
        .ext_predivide_o(ext_predivide_o), .mult_factor_o(mult_factor_o), .usb_div_o(usb_div_o),
        .clock_output_sel_o(clock_output_sel_o));
    initial begin
        clk_i = 0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic conclude;
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask
    // one classic cycle, waits for ack
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= wr; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 0; stb_i <= 0;
        if (n >= 20) chk("ack", 32'h1, 32'h0);
    endtask
    task automatic wait_src(input logic [1:0] s);
        for (int n = 0; n < 30 && root_source_o !== s; n++) @(posedge clk_i);
    endtask
    function automatic logic [4:0] fac(input logic [3:0] c);
        return (c == 4'hF) ? 5'h10 : {1'b0, c} + 5'h02;
    endfunction
    task automatic chk_src(input string nm, input logic [1:0] x);
        chk(nm, {30'h0, x}, {30'h0, root_source_o});
    endtask
    // one-cycle wake or failure pulse, then two settling edges
    task automatic pulse(input logic wk, input logic fl);
        wake_i     <= wk;
        ext_fail_i <= fl;
        @(posedge clk_i);
        wake_i     <= 1'b0;
        ext_fail_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // settle past the counter wrap, then count over whole periods
    task automatic count_ticks(input logic [31:0] d, input int len, input int ec, input int el, input int eh,
                               input int ev);
        wb(1, CFG_OFFSET, d);
        repeat (200) @(posedge clk_i);
        t = '{default: 0};
        repeat (len) begin
            @(posedge clk_i);
            t[0] += core_tick_o; t[1] += low_speed_tick_o; t[2] += high_speed_tick_o; t[3] += converter_tick_o;
        end
        chk("core", ec, t[0]);
        chk("low", el, t[1]);
        chk("high", eh, t[2]);
        chk("conv", ev, t[3]);
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        conclude();
    end
    initial begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, wake_i, security_en_i, ext_fail_i} = '0;
        {mult_enabled_i, usb_clk_enabled_i, ext_ready_i} = '0;
        {rst_i, rc_ready_i, mult_ready_i} = 3'h7;
        n_errors = 0; checked = 0;
        void'($urandom(32'h5fd1));
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        wb(0, CFG_OFFSET, 0); chk("reset", CFG_RESET, q);
        for (i = 0; i < 8; i++) begin
            w = $urandom & 32'hFFFF_FFFC;
            if (i == 0) w = w | 32'h003C_0000;
            if (i == 1) w = w & 32'hFFC3_FFFF;
            e = w & ~(STATUS_MASK | RESERVED_MASK);
            wb(1, CFG_OFFSET, w); wb(0, CFG_OFFSET, 0); chk("cfg", e, q);
            chk("factor", {27'h0, fac(w[21:18])}, {27'h0, mult_factor_o});
            chk("outs", {25'h0, w[26:22], w[17:16]}, {25'h0, clock_output_sel_o, usb_div_o,
                ext_predivide_o, mult_ref_ext_o});
        end
        // usb divider is already set before its clock is enabled
        mult_enabled_i <= 1; usb_clk_enabled_i <= 1;
        wb(1, CFG_OFFSET, e ^ 32'h00FF_FFF0); wb(0, CFG_OFFSET, 0);
        chk("lock", (e ^ 32'h0000_FFF0) & ~RESERVED_MASK, q);
        mult_enabled_i <= 0; usb_clk_enabled_i <= 0;
        wb(1, 8'h08, 32'hFFFF_FFFF); wb(0, 8'h08, 0); chk("unmapped", 32'h0, q);
        count_ticks(32'h0000_2490, 64, 16, 8, 8, 4);
        count_ticks(32'h0000_EF80, 128, 64, 4, 16, 2);
        count_ticks(32'h0000_00C0, 256, 4, 4, 4, 2);
        wb(1, CFG_OFFSET, 32'h1);
        repeat (6) @(posedge clk_i);
        chk_src("wait", 2'h0);
        ext_ready_i <= 1;
        wb(0, CFG_OFFSET, 0); wait_src(2'h1); chk_src("ext", 2'h1);
        pulse(1'b0, 1'b1); chk_src("unguarded", 2'h1);
        security_en_i <= 1;
        pulse(1'b0, 1'b1); wb(0, CFG_OFFSET, 0); chk("fallback", 32'h0, {28'h0, q[3:0]});
        wb(1, CFG_OFFSET, 32'h2); wait_src(2'h2); chk_src("mult", 2'h2);
        pulse(1'b0, 1'b1); chk_src("rc_ref", 2'h2);
        pulse(1'b1, 1'b0); chk_src("wake", 2'h0);
        wb(1, CFG_OFFSET, 32'h0001_0002); wait_src(2'h2); chk_src("ext_ref", 2'h2);
        pulse(1'b0, 1'b1); chk_src("ref_fail", 2'h0);
        wb(1, CFG_OFFSET, 32'h3);
        repeat (8) @(posedge clk_i);
        chk_src("reserved", 2'h0);
        conclude();
    end
endmodule
`default_nettype wire
